// [logic/xci_pkg.sv]
/*
   Constants and types shared by the exclusive-OR / compare / increment
   datapath slice: opcode patterns, register codes, flag positions,
   machine-cycle lengths, software port map and state encodings.
   Assumes one 50 MHz clock and a byte-wide synchronous memory partner.
*/
// Contract
// - xor writes accumulator xor selected operand back into the accumulator
// - xor decodes as 10101rrr, EE n, AE, or DD/FD AE d
// - register field 000..101 selects B,C,D,E,H,L and 111 the accumulator
// - xor flags: sign bit 7, zero, even parity; half, subtract, carry cleared
// - xor/compare take 4 states register, 7 immediate/pointer, 19 indexed
// - compare subtracts operand for flags only; accumulator unchanged, zero on equal
// - compare decodes as 10111rrr, FE n, BE, or DD/FD BE d
// - compare flags: sign, zero, half borrow bit 4, overflow, borrow, subtract set
// - register increment adds one and stores back into the same register
// - opcode 34 increments the byte addressed by the pointer pair in place
// - indexed increment addresses index register plus signed displacement
// - increment flags: sign, zero, half from bit 3, overflow at 7F; carry kept
// - increment takes 4 states register, 11 pointer pair, 23 indexed
package xci_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // opcode patterns
   localparam logic [7:0] OPC_XOR_IMM = 8'hEE;
   localparam logic [7:0] OPC_CMP_IMM = 8'hFE;
   localparam logic [7:0] OPC_PFX_X   = 8'hDD;
   localparam logic [7:0] OPC_PFX_Y   = 8'hFD;
   localparam logic [4:0] XOR_REG_TOP = 5'h15;
   localparam logic [4:0] CMP_REG_TOP = 5'h17;
   localparam logic [1:0] INC_REG_TOP = 2'h0;
   localparam logic [2:0] INC_REG_LOW = 3'h4;

   ////////////////////////////////////////////////////////////////////////////
   // register codes; code 6 means memory, its slot holds the flags
   localparam logic [2:0] R_B   = 3'h0;
   localparam logic [2:0] R_H   = 3'h4;
   localparam logic [2:0] R_L   = 3'h5;
   localparam logic [2:0] R_MEM = 3'h6;
   localparam logic [2:0] R_F   = 3'h6;
   localparam logic [2:0] R_A   = 3'h7;

   ////////////////////////////////////////////////////////////////////////////
   // flag bit positions
   localparam int FL_S  = 7;
   localparam int FL_Z  = 6;
   localparam int FL_H  = 4;
   localparam int FL_PV = 2;
   localparam int FL_N  = 1;
   localparam int FL_C  = 0;

   ////////////////////////////////////////////////////////////////////////////
   // machine-cycle lengths in states
   localparam logic [2:0] LEN_M1   = 3'h4;
   localparam logic [2:0] LEN_RD   = 3'h3;
   localparam logic [2:0] LEN_RD4  = 3'h4;
   localparam logic [2:0] LEN_CALC = 3'h5;
   localparam logic [2:0] LEN_WR   = 3'h3;

   ////////////////////////////////////////////////////////////////////////////
   // timing: one state lasts at least a 4 MHz period
   localparam int CLK_NS     = 20;
   localparam int T_STATE_NS = 250;
   localparam int T_CYC      = (T_STATE_NS + CLK_NS - 1) / CLK_NS;

   ////////////////////////////////////////////////////////////////////////////
   // software port map
   localparam logic [3:0] A_IXL  = 4'h8;
   localparam logic [3:0] A_IXH  = 4'h9;
   localparam logic [3:0] A_IYL  = 4'hA;
   localparam logic [3:0] A_IYH  = 4'hB;
   localparam logic [3:0] A_PCL  = 4'hC;
   localparam logic [3:0] A_PCH  = 4'hD;
   localparam logic [3:0] A_CTRL = 4'hE;
   localparam logic [3:0] A_STAT = 4'hF;
   localparam int CTRL_RUN  = 0;
   localparam int STAT_BUSY = 0;
   localparam int STAT_PFX  = 1;
   localparam logic [7:0]  RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;

   ////////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [1:0] {OP_XOR, OP_CMP, OP_INC, OP_NOP} xci_op_t;
   typedef enum logic [1:0] {FM_REG, FM_IMM, FM_PTR, FM_IDX} xci_form_t;
   typedef enum logic [5:0] {
      ST_IDLE  = 6'h01,
      ST_FETCH = 6'h02,
      ST_DISP  = 6'h04,
      ST_CALC  = 6'h08,
      ST_READ  = 6'h10,
      ST_WRITE = 6'h20
   } xci_state_t;

endpackage

// [logic/xci_tick_div.sv]
/*
   State-rate divider: one-cycle enable pulse every DIV clocks.
   Assumes the single core clock; free running after reset.
*/
module xci_tick_div #(
   parameter int unsigned DIV = 13
) (
   input  wire logic i_mclk,
   input  wire logic i_resetn,
   output logic      o_tick
);
   localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);
   localparam logic [CW-1:0] ZERO = '0;

   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;

   ////////////////////////////////////////////////////////////////////////////
   // wrap counter
   always_comb begin
      cnt_d = (cnt_q == LAST) ? ZERO : cnt_q + CW'(1);
   end

   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         cnt_q <= ZERO;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign o_tick = (cnt_q == LAST);  // pulse on the wrap cycle
endmodule

// [logic/xci_alu.sv]
/*
   Combinational result and flag unit for exclusive-OR, compare and
   increment. Flag bits 5 and 3 pass through from the old flags.
   Assumes the caller chooses the operand and what is written back.
*/
module xci_alu
   import xci_pkg::*;
(
   input  xci_op_t    i_op,
   input  wire [7:0]  i_acc,
   input  wire [7:0]  i_opnd,
   input  wire [7:0]  i_flags,
   output logic [7:0] o_res,
   output logic [7:0] o_flags
);
   logic [8:0] diff;

   ////////////////////////////////////////////////////////////////////////////
   // result and flags
   always_comb begin
      diff    = {1'b0, i_acc} - {1'b0, i_opnd};
      o_res   = i_acc;
      o_flags = i_flags;
      case (i_op)
         OP_XOR: begin
            o_res = i_acc ^ i_opnd;
            o_flags[FL_S]  = o_res[7];
            o_flags[FL_Z]  = (o_res == 8'h00);
            o_flags[FL_H]  = 1'b0;
            o_flags[FL_PV] = ~^o_res;
            o_flags[FL_N]  = 1'b0;
            o_flags[FL_C]  = 1'b0;
         end
         OP_CMP: begin
            o_res = i_acc;
            o_flags[FL_S]  = diff[7];
            o_flags[FL_Z]  = (diff[7:0] == 8'h00);
            o_flags[FL_H]  = (i_acc[3:0] < i_opnd[3:0]);
            o_flags[FL_PV] = (i_acc[7] ^ i_opnd[7]) & (diff[7] ^ i_acc[7]);
            o_flags[FL_N]  = 1'b1;
            o_flags[FL_C]  = diff[8];
         end
         OP_INC: begin
            o_res = i_opnd + 8'h01;
            o_flags[FL_S]  = o_res[7];
            o_flags[FL_Z]  = (o_res == 8'h00);
            o_flags[FL_H]  = (i_opnd[3:0] == 4'hF);
            o_flags[FL_PV] = (i_opnd == 8'h7F);
            o_flags[FL_N]  = 1'b0;
         end
         default: begin
            o_res = i_acc;
         end
      endcase
   end
endmodule

// [logic/xci_core.sv]
/*
   Datapath slice that runs exclusive-OR, compare and increment
   instructions from a byte-wide memory, with working registers
   reachable over a plain software port. Unknown opcodes retire as
   4-state no-ops. Assumes the memory runs on i_mclk and returns read
   data in the cycle after o_mem_rd, and takes a write with o_mem_wr.
*/
module xci_core
   import xci_pkg::*;
#(
   parameter int unsigned TICK_DIV = T_CYC
) (
   input  wire logic        i_mclk,
   input  wire logic        i_resetn,
   input  wire logic [3:0]  i_addr,
   input  wire logic [7:0]  i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [7:0]  o_rdata,
   output logic      [15:0] o_mem_addr,
   output logic             o_mem_rd,
   output logic             o_mem_wr,
   output logic      [7:0]  o_mem_wdata,
   input  wire logic [7:0]  i_mem_rdata,
   output logic             o_busy,
   output logic             o_done
);

   ////////////////////////////////////////////////////////////////////////////
   // state
   xci_state_t  state_q, state_d;
   xci_op_t     op_q, op_d;
   xci_form_t   form_q, form_d;
   logic [2:0]  tcnt_q, tcnt_d;
   logic [2:0]  len_q, len_d;
   logic [2:0]  rsel_q, rsel_d;
   logic        pfx_q, pfx_d;
   logic        idxy_q, idxy_d;
   logic        run_q, run_d;
   logic [15:0] pc_q, pc_d;
   logic [15:0] idx_x_q, idx_x_d;
   logic [15:0] idx_y_q, idx_y_d;
   logic [15:0] addr_q, addr_d;
   logic [7:0]  mdata_q, mdata_d;
   logic [7:0]  wdata_q, wdata_d;
   logic [7:0]  rdata_q, rdata_d;
   logic        rd_pend_q, rd_pend_d;
   logic        mem_rd_q, mem_rd_d;
   logic        mem_wr_q, mem_wr_d;
   logic        done_q, done_d;
   logic [7:0]  regs_q [0:7];
   logic [7:0]  regs_d [0:7];

   logic        tick;
   logic        last;
   logic        go;
   logic        fin;
   logic        commit;
   logic        rd_pc;
   xci_op_t     dec_op, cur_op;
   xci_form_t   dec_form, cur_form;
   logic [2:0]  dec_r, cur_r;
   logic [7:0]  alu_opnd;
   logic [7:0]  alu_res;
   logic [7:0]  alu_flags;
   logic [15:0] idx_base;

   ////////////////////////////////////////////////////////////////////////////
   // state-rate enable
   xci_tick_div #(
      .DIV (TICK_DIV)
   ) u_div (
      .i_mclk   (i_mclk),
      .i_resetn (i_resetn),
      .o_tick   (tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // opcode decode of the last fetched byte
   always_comb begin
      dec_op   = OP_NOP;
      dec_form = FM_REG;
      dec_r    = mdata_q[2:0];
      if (mdata_q[7:3] == XOR_REG_TOP) begin
         dec_op   = OP_XOR;
         dec_form = (dec_r == R_MEM) ? FM_PTR : FM_REG;
      end else if (mdata_q[7:3] == CMP_REG_TOP) begin
         dec_op   = OP_CMP;
         dec_form = (dec_r == R_MEM) ? FM_PTR : FM_REG;
      end else if (mdata_q == OPC_XOR_IMM) begin
         dec_op   = OP_XOR;
         dec_form = FM_IMM;
      end else if (mdata_q == OPC_CMP_IMM) begin
         dec_op   = OP_CMP;
         dec_form = FM_IMM;
      end else if (mdata_q[7:6] == INC_REG_TOP && mdata_q[2:0] == INC_REG_LOW) begin
         dec_op   = OP_INC;
         dec_r    = mdata_q[5:3];
         dec_form = (dec_r == R_MEM) ? FM_PTR : FM_REG;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // operand selection and arithmetic
   always_comb begin
      cur_op   = (state_q == ST_FETCH) ? dec_op : op_q;
      cur_form = (state_q == ST_FETCH) ? dec_form : form_q;
      cur_r    = (state_q == ST_FETCH) ? dec_r : rsel_q;
      alu_opnd = (cur_form == FM_REG) ? regs_q[cur_r] : mdata_q;
      idx_base = idxy_q ? idx_y_q : idx_x_q;
   end

   xci_alu u_alu (
      .i_op    (cur_op),
      .i_acc   (regs_q[R_A]),
      .i_opnd  (alu_opnd),
      .i_flags (regs_q[R_F]),
      .o_res   (alu_res),
      .o_flags (alu_flags)
   );

   ////////////////////////////////////////////////////////////////////////////
   // sequencer, memory cycles, register writeback and software port
   always_comb begin
      state_d   = state_q;
      op_d      = op_q;
      form_d    = form_q;
      tcnt_d    = tcnt_q;
      len_d     = len_q;
      rsel_d    = rsel_q;
      pfx_d     = pfx_q;
      idxy_d    = idxy_q;
      run_d     = run_q;
      pc_d      = pc_q;
      idx_x_d   = idx_x_q;
      idx_y_d   = idx_y_q;
      addr_d    = addr_q;
      wdata_d   = wdata_q;
      regs_d    = regs_q;
      mem_rd_d  = 1'b0;
      mem_wr_d  = 1'b0;
      done_d    = 1'b0;
      rd_pend_d = mem_rd_q;
      mdata_d   = rd_pend_q ? i_mem_rdata : mdata_q;
      go        = 1'b0;
      fin       = 1'b0;
      commit    = 1'b0;
      rd_pc     = 1'b0;
      last      = (tcnt_q == len_q - 3'h1);

      // software writes; working state only while idle
      if (i_wr) begin
         if (i_addr == A_CTRL) begin
            run_d = i_wdata[CTRL_RUN];
         end else if (state_q == ST_IDLE) begin
            case (i_addr)
               A_IXL:   idx_x_d[7:0]  = i_wdata;
               A_IXH:   idx_x_d[15:8] = i_wdata;
               A_IYL:   idx_y_d[7:0]  = i_wdata;
               A_IYH:   idx_y_d[15:8] = i_wdata;
               A_PCL:   pc_d[7:0]  = i_wdata;
               A_PCH:   pc_d[15:8] = i_wdata;
               A_STAT:  ;
               default: regs_d[i_addr[2:0]] = i_wdata;
            endcase
         end
      end

      // software reads, data in the next cycle only
      rdata_d = RST_BYTE;
      if (i_rd) begin
         case (i_addr)
            A_IXL:   rdata_d = idx_x_q[7:0];
            A_IXH:   rdata_d = idx_x_q[15:8];
            A_IYL:   rdata_d = idx_y_q[7:0];
            A_IYH:   rdata_d = idx_y_q[15:8];
            A_PCL:   rdata_d = pc_q[7:0];
            A_PCH:   rdata_d = pc_q[15:8];
            A_CTRL:  rdata_d = {7'h00, run_q};
            A_STAT:  rdata_d = {6'h00, pfx_q, state_q != ST_IDLE};
            default: rdata_d = regs_q[i_addr[2:0]];
         endcase
      end

      if (tick) begin
         tcnt_d = tcnt_q + 3'h1;
         case (state_q)
            ST_IDLE: begin
               tcnt_d = 3'h0;
               go     = run_q;
            end
            ST_FETCH: begin
               if (last) begin
                  op_d   = dec_op;
                  rsel_d = dec_r;
                  if (!pfx_q && (mdata_q == OPC_PFX_X || mdata_q == OPC_PFX_Y)) begin
                     pfx_d  = 1'b1;
                     idxy_d = (mdata_q == OPC_PFX_Y);
                     go     = 1'b1;
                  end else if (pfx_q) begin
                     if (dec_form == FM_PTR && dec_op != OP_NOP) begin
                        form_d  = FM_IDX;
                        state_d = ST_DISP;
                        len_d   = LEN_RD;
                        rd_pc   = 1'b1;
                     end else begin
                        fin = 1'b1;
                     end
                  end else begin
                     form_d = dec_form;
                     case (dec_form)
                        FM_IMM: begin
                           state_d = ST_READ;
                           len_d   = LEN_RD;
                           rd_pc   = 1'b1;
                        end
                        FM_PTR: begin
                           state_d  = ST_READ;
                           len_d    = (dec_op == OP_INC) ? LEN_RD4 : LEN_RD;
                           tcnt_d   = 3'h0;
                           addr_d   = {regs_q[R_H], regs_q[R_L]};
                           mem_rd_d = 1'b1;
                        end
                        default: begin
                           commit = (dec_op != OP_NOP);
                           fin    = 1'b1;
                        end
                     endcase
                  end
               end
            end
            ST_DISP: begin
               if (last) begin
                  state_d = ST_CALC;
                  len_d   = LEN_CALC;
                  tcnt_d  = 3'h0;
               end
            end
            ST_CALC: begin
               if (last) begin
                  state_d  = ST_READ;
                  len_d    = (op_q == OP_INC) ? LEN_RD4 : LEN_RD;
                  tcnt_d   = 3'h0;
                  addr_d   = idx_base + {{8{mdata_q[7]}}, mdata_q};
                  mem_rd_d = 1'b1;
               end
            end
            ST_READ: begin
               if (last) begin
                  commit = 1'b1;
                  if (op_q == OP_INC) begin
                     state_d  = ST_WRITE;
                     len_d    = LEN_WR;
                     tcnt_d   = 3'h0;
                     wdata_d  = alu_res;
                     mem_wr_d = 1'b1;
                  end else begin
                     fin = 1'b1;
                  end
               end
            end
            ST_WRITE: begin
               fin = last;
            end
            default: begin
               state_d = ST_IDLE;
               tcnt_d  = 3'h0;
            end
         endcase
      end

      // operand read at the program counter
      if (rd_pc) begin
         tcnt_d   = 3'h0;
         addr_d   = pc_q;
         pc_d     = pc_q + 16'h0001;
         mem_rd_d = 1'b1;
      end

      // result and flag writeback
      if (commit) begin
         regs_d[R_F] = alu_flags;
         if (cur_op == OP_XOR) begin
            regs_d[R_A] = alu_res;
         end else if (cur_op == OP_INC && cur_form == FM_REG) begin
            regs_d[cur_r] = alu_res;
         end
      end

      // retire, then fetch the next opcode or stop
      if (fin) begin
         done_d  = 1'b1;
         pfx_d   = 1'b0;
         go      = run_q;
         state_d = ST_IDLE;
      end
      if (go) begin
         state_d  = ST_FETCH;
         len_d    = LEN_M1;
         tcnt_d   = 3'h0;
         addr_d   = pc_q;
         pc_d     = pc_q + 16'h0001;
         mem_rd_d = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         state_q   <= ST_IDLE;
         op_q      <= OP_NOP;
         form_q    <= FM_REG;
         tcnt_q    <= 3'h0;
         len_q     <= LEN_M1;
         rsel_q    <= R_B;
         pfx_q     <= 1'b0;
         idxy_q    <= 1'b0;
         run_q     <= 1'b0;
         pc_q      <= RST_WORD;
         idx_x_q   <= RST_WORD;
         idx_y_q   <= RST_WORD;
         addr_q    <= RST_WORD;
         mdata_q   <= RST_BYTE;
         wdata_q   <= RST_BYTE;
         rdata_q   <= RST_BYTE;
         rd_pend_q <= 1'b0;
         mem_rd_q  <= 1'b0;
         mem_wr_q  <= 1'b0;
         done_q    <= 1'b0;
         for (int i = 0; i < 8; i++) begin
            regs_q[i] <= RST_BYTE;
         end
      end else begin
         state_q   <= state_d;
         op_q      <= op_d;
         form_q    <= form_d;
         tcnt_q    <= tcnt_d;
         len_q     <= len_d;
         rsel_q    <= rsel_d;
         pfx_q     <= pfx_d;
         idxy_q    <= idxy_d;
         run_q     <= run_d;
         pc_q      <= pc_d;
         idx_x_q   <= idx_x_d;
         idx_y_q   <= idx_y_d;
         addr_q    <= addr_d;
         mdata_q   <= mdata_d;
         wdata_q   <= wdata_d;
         rdata_q   <= rdata_d;
         rd_pend_q <= rd_pend_d;
         mem_rd_q  <= mem_rd_d;
         mem_wr_q  <= mem_wr_d;
         done_q    <= done_d;
         regs_q    <= regs_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign o_rdata     = rdata_q;
   assign o_mem_addr  = addr_q;
   assign o_mem_rd    = mem_rd_q;
   assign o_mem_wr    = mem_wr_q;
   assign o_mem_wdata = wdata_q;
   assign o_busy      = (state_q != ST_IDLE);
   assign o_done      = done_q;
endmodule

// [testbench/xci_core_assertions.sv]
/*
   Port checker for the xor / compare / increment slice.
   Assumes one clock, low-active asynchronous reset, bound to xci_core.
*/
module xci_core_chk
   import xci_pkg::*;
#(
   parameter int unsigned TICK_DIV = T_CYC
) (
   input wire logic        i_mclk,
   input wire logic        i_resetn,
   input wire logic [3:0]  i_addr,
   input wire logic [7:0]  i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input logic      [7:0]  o_rdata,
   input logic      [15:0] o_mem_addr,
   input logic             o_mem_rd,
   input logic             o_mem_wr,
   input logic      [7:0]  o_mem_wdata,
   input wire logic [7:0]  i_mem_rdata,
   input logic             o_busy,
   input logic             o_done
);
   logic [7:0]  gap_q, gap_d, dat_q, dat_d;
   logic [15:0] adr_q, adr_d;
   logic        rdp_q, rdp_d;

   ////////////////////////////////////////////////////////////////////////////
   // clocks since last read, its address and returned byte
   always_comb begin
      gap_d = o_mem_rd ? 8'h01 : ((gap_q == 8'hFF) ? gap_q : gap_q + 8'h01);
      adr_d = o_mem_rd ? o_mem_addr : adr_q;
      rdp_d = o_mem_rd;
      dat_d = rdp_q ? i_mem_rdata : dat_q;
   end

   // helper registers
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         gap_q <= 8'hFF;
         adr_q <= 16'h0000;
         rdp_q <= 1'b0;
         dat_q <= 8'h00;
      end else begin
         gap_q <= gap_d;
         adr_q <= adr_d;
         rdp_q <= rdp_d;
         dat_q <= dat_d;
      end
   end

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_resetn);

   // five clocks of silence after a write
   sequence s_mem_quiet;
      (!o_mem_rd && !o_mem_wr) [*5];
   endsequence
   sequence s_rd_pulse;
      o_mem_rd ##1 !o_mem_rd;
   endsequence

   rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data outside read answer");
   mem_excl_a: assert property (!(o_mem_rd && o_mem_wr))
      else $error("read and write together");
   rd_pulse_a: assert property (o_mem_rd |-> s_rd_pulse)
      else $error("read request longer than one cycle");
   done_busy_a: assert property (o_done |-> $past(o_busy) ##1 !o_done)
      else $error("done without busy or too long");
   wr_addr_a: assert property (o_mem_wr |-> o_mem_addr == adr_q)
      else $error("write address differs from read");
   wr_data_a: assert property (o_mem_wr |-> o_mem_wdata == dat_q + 8'h01)
      else $error("written byte is not read byte plus one");
   wr_gap_a: assert property (o_mem_wr |-> gap_q == 8'(4 * TICK_DIV))
      else $error("operand read not four states long");
   rd_gap_a: assert property (o_mem_rd |-> gap_q >= 8'(3 * TICK_DIV))
      else $error("machine cycle shorter than three states");
   wr_quiet_a: assert property (o_mem_wr |=> s_mem_quiet)
      else $error("access inside write cycle");
endmodule

bind xci_core xci_core_chk #(.TICK_DIV(TICK_DIV)) u_xci_core_chk (
   .i_mclk(i_mclk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_mem_addr(o_mem_addr),
   .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .o_mem_wdata(o_mem_wdata),
   .i_mem_rdata(i_mem_rdata), .o_busy(o_busy), .o_done(o_done));

// [testbench/xci_mem_model.sv]
/*
   Byte-wide memory partner: data one cycle after a read request.
   Assumes the core clock; bench preloads mem directly.
*/
module xci_mem_model (
   input wire logic        i_mclk,
   input wire logic [15:0] i_mem_addr,
   input wire logic        i_mem_rd,
   input wire logic        i_mem_wr,
   input wire logic [7:0]  i_mem_wdata,
   output logic     [7:0]  o_mem_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [0:65535];

   // stale data toggles so a late capture is seen
   initial o_mem_rdata = 8'h00;
   always @(posedge i_mclk) begin
      if (i_mem_wr) mem[i_mem_addr] <= i_mem_wdata;
      if (i_mem_rd) o_mem_rdata <= mem[i_mem_addr];
      else o_mem_rdata <= ~o_mem_rdata;
   end
endmodule

// [testbench/test_xci_core.sv]
/*
   Self-checking bench: runs single instructions from the memory model.
   Assumes TICK_DIV of 2 and the software port map of the package.
*/
module test_xci_core;
   import xci_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic        i_mclk = 1'b0, i_resetn = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
   logic [3:0]  i_addr = 4'h0;
   logic [7:0]  i_wdata = 8'h00, o_rdata, o_mem_wdata, i_mem_rdata, rv;
   logic [15:0] o_mem_addr;
   logic        o_mem_rd, o_mem_wr, o_busy, o_done;
   int          n_errors = 0, n_tests = 0, n_rd = 0, n_wr = 0, n_bsy = 0;
   localparam int TDIV = 2;  // clocks per state

   xci_core #(.TICK_DIV(TDIV)) u_xci_core (.i_mclk(i_mclk), .i_resetn(i_resetn),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr),
      .o_mem_wdata(o_mem_wdata), .i_mem_rdata(i_mem_rdata), .o_busy(o_busy),
      .o_done(o_done));
   xci_mem_model u_xci_mem_model (.i_mclk(i_mclk), .i_mem_addr(o_mem_addr),
      .i_mem_rd(o_mem_rd), .i_mem_wr(o_mem_wr), .i_mem_wdata(o_mem_wdata),
      .o_mem_rdata(i_mem_rdata));

   ////////////////////////////////////////////////////////////////////////////
   // clock and access counters
   initial forever #10 i_mclk = ~i_mclk;
   always @(posedge i_mclk) begin
      n_rd += o_mem_rd;
      n_wr += o_mem_wr;
      n_bsy += o_busy;
   end

   task chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask
   task rchk(input logic [3:0] a, input logic [7:0] exp);
      @(posedge i_mclk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 chk(o_rdata, exp);
   endtask
   // run one instruction from address 0, count its accesses
   task exec(input logic [7:0] b0, b1, b2, input int nr, input int nw);
      int k, st;
      u_xci_mem_model.mem[0] = b0;
      u_xci_mem_model.mem[1] = b1;
      u_xci_mem_model.mem[2] = b2;
      wr(A_PCL, 8'h00);
      wr(A_PCH, 8'h00);
      n_rd = 0;
      n_wr = 0;
      n_bsy = 0;
      wr(A_CTRL, 8'h01);
      for (k = 0; k < 100 && o_busy !== 1'b1; k++) begin
         @(posedge i_mclk);
         #1;
      end
      wr(A_CTRL, 8'h00);
      for (k = 0; k < 200 && o_done !== 1'b1; k++) begin
         @(posedge i_mclk);
         #1;
      end
      chk(o_done, 1'b1);
      repeat (4) @(posedge i_mclk);
      chk(16'(n_rd), 16'(nr));
      chk(16'(n_wr), 16'(nw));
      // states per form: 4, 7, 19, plus 4 for a write-back
      st = (nr == 1) ? 4 : (nr == 2) ? 7 : 19;
      st = st + 4 * nw;
      chk(16'(n_bsy), 16'(TDIV * st));
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   task t_reset;
      for (int a = 0; a < 16; a++) rchk(4'(a), RST_BYTE);
   endtask
   task t_xor;
      for (int r = 0; r < 6; r++) begin
         wr(4'(r), 8'(8'h11 * (r + 1)));
         wr(R_A, 8'hFF);
         exec(8'(8'hA8 + r), 8'h00, 8'h00, 1, 0);
         rchk(R_A, 8'(~(8'h11 * (r + 1))));
      end
      wr(R_A, 8'h96);
      wr(R_F, 8'hFF);
      exec(8'hEE, 8'h5D, 8'h00, 2, 0);
      rchk(R_A, 8'hCB);
      rchk(R_F, 8'hA8);
      exec(8'hAF, 8'h00, 8'h00, 1, 0);
      rchk(R_F, 8'h6C);
      wr(R_H, 8'h40);
      wr(R_L, 8'h00);
      wr(R_A, 8'h0F);
      u_xci_mem_model.mem[16'h4000] = 8'hF0;
      exec(8'hAE, 8'h00, 8'h00, 2, 0);
      rchk(R_A, 8'hFF);
      rchk(R_F, 8'hAC);
      wr(A_IXH, 8'h20);
      wr(A_IXL, 8'h20);
      u_xci_mem_model.mem[16'h2030] = 8'hFF;
      exec(OPC_PFX_X, 8'hAE, 8'h10, 4, 0);
      rchk(R_A, 8'h00);
      rchk(R_F, 8'h6C);
   endtask
   task t_cmp;
      wr(R_A, 8'h63);
      wr(R_F, 8'h00);
      u_xci_mem_model.mem[16'h4000] = 8'h60;
      exec(8'hBE, 8'h00, 8'h00, 2, 0);
      rchk(R_F, 8'h02);
      exec(OPC_CMP_IMM, 8'h63, 8'h00, 2, 0);
      rchk(R_F, 8'h42);
      exec(OPC_CMP_IMM, 8'h64, 8'h00, 2, 0);
      rchk(R_F, 8'h93);
      wr(A_IYH, 8'h30);
      wr(A_IYL, 8'h00);
      u_xci_mem_model.mem[16'h2FF0] = 8'h80;
      exec(OPC_PFX_Y, 8'hBE, 8'hF0, 4, 0);
      rchk(R_F, 8'h87);
      wr(R_B, 8'h63);
      exec(8'hB8, 8'h00, 8'h00, 1, 0);
      rchk(R_F, 8'h42);
      rchk(R_A, 8'h63);
   endtask
   task t_inc;
      for (int r = 0; r < 8; r++) begin
         if (r != 6) begin
            wr(4'(r), 8'h7F);
            wr(R_F, 8'h01);
            exec(8'(r * 8 + 4), 8'h00, 8'h00, 1, 0);
            rchk(4'(r), 8'h80);
            rchk(R_F, 8'h95);
         end
      end
      wr(R_H, 8'h40);
      wr(R_L, 8'h00);
      u_xci_mem_model.mem[16'h4000] = 8'hFF;
      exec(8'h34, 8'h00, 8'h00, 2, 1);
      chk(u_xci_mem_model.mem[16'h4000], 8'h00);
      rchk(R_F, 8'h51);
      wr(R_F, 8'h00);
      u_xci_mem_model.mem[16'h2030] = 8'h34;
      exec(OPC_PFX_X, 8'h34, 8'h10, 4, 1);
      chk(u_xci_mem_model.mem[16'h2030], 8'h35);
      u_xci_mem_model.mem[16'h2FF0] = 8'h0F;
      exec(OPC_PFX_Y, 8'h34, 8'hF0, 4, 1);
      chk(u_xci_mem_model.mem[16'h2FF0], 8'h10);
      rchk(R_F, 8'h10);
   endtask

   task results;
      $display("errors %0d tests %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      repeat (6) @(posedge i_mclk);
      i_resetn <= 1'b1;
      t_reset;
      t_xor;
      t_cmp;
      t_inc;
      results;
   end
   // watchdog well beyond the expected run
   initial begin
      #1000000;
      n_errors++;
      results;
   end
endmodule
